// ### pkg/amp_cfg_pkg.sv
// constants for the amplifier configuration bank
package amp_cfg_pkg;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 4;
    // register indices on the serial link
    localparam logic [3:0] IDX_FINE_OFFSET = 4'h0;
    localparam logic [3:0] IDX_FINE_GAIN = 4'h1;
    localparam logic [3:0] IDX_GAIN_OFFSET = 4'h2;
    localparam logic [3:0] IDX_FAULT_LIMIT = 4'h3;
    localparam logic [3:0] IDX_LINK_OUTPUT = 4'h4;
    localparam logic [3:0] IDX_CHECKSUM = 4'h5;
    localparam logic [3:0] IDX_CHECKSUM_READBACK = 4'h6;
    localparam logic [3:0] IDX_STATUS = 4'h7;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    // gain_offset_config fields
    localparam int POS_INPUT_SWAP = 12;
    localparam int POS_FRONT_GAIN = 8;
    localparam int POS_COARSE_OFFSET = 0;
    // fault_and_limit_config fields
    localparam int POS_FAULT_REF = 15;
    localparam int POS_PULLUP_DIS = 14;
    localparam int POS_LIMIT_REF = 13;
    localparam int POS_FAULT_MODE = 12;
    localparam int POS_LIMIT_COMP = 11;
    localparam int POS_EXT_FAULT_GROUP_EN = 10;
    localparam int POS_INT_EN = 9;
    localparam int POS_EXT_FAULT_POLARITY = 8;
    localparam int POS_INT_FAULT_POLARITY = 7;
    localparam int POS_LIMIT_EN = 6;
    localparam int POS_HIGH_LIMIT = 3;
    localparam int POS_LOW_LIMIT = 0;
    // link_output_power_config fields
    localparam int POS_LINK_DIS = 15;
    localparam int POS_LINK_DIS_NOW = 14;
    localparam int POS_OUT_DIS = 13;
    localparam int POS_INSTANT_ON = 12;
    localparam int POS_OFFSET_RANGE = 10;
    localparam int POS_PIN_DIGITAL = 8;
    localparam int POS_PIN_STATE = 7;
    localparam int POS_SHUTDOWN = 6;
    // status word field
    localparam int POS_CHECKSUM_OK = 6;
    // coarse offset magnitude ceiling
    localparam logic [6:0] OFFSET_MAG_MAX = 7'h64;
    localparam int EXT_FAULT_N = 4;
    localparam int INT_FAULT_N = 5;
    localparam int SUM_WORDS = 5;
    // timing
    localparam int CLOCK_PERIOD_NS = 10;
    localparam int FAST_ON_US = 60;
    localparam int SLOW_DELAY_MS = 25;
    localparam int FAST_ON_CYCLES = FAST_ON_US * 1000 / CLOCK_PERIOD_NS;
    localparam int SLOW_DELAY_CYCLES =
        SLOW_DELAY_MS * 1000000 / CLOCK_PERIOD_NS;
    localparam int TIMER_W = 22;
endpackage : amp_cfg_pkg

// ### hdl/checksum_engine.sv
// sequential end-around-carry checksum over the stored words
`timescale 1ns/1ps
module checksum_engine
    import amp_cfg_pkg::*;
(
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic start_in,
    input wire logic [15:0] word_in,
    output logic [2:0] word_sel_out,
    output logic busy_out,
    output logic done_out,
    output logic [15:0] sum_out
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADD = 2'b01,
        ST_DONE = 2'b10
    } eng_state_t;

    eng_state_t state_r;
    eng_state_t state_nxt;
    logic [2:0] sel_r;
    logic [15:0] acc_r;
    logic [15:0] sum_r;
    logic [16:0] raw_sum;
    logic [15:0] folded;
    logic last_word;

    // carry out folds back into the low bit
    assign raw_sum = {1'b0, acc_r} + {1'b0, word_in};
    assign folded = raw_sum[15:0] + {15'h0000, raw_sum[16]};
    assign last_word = (sel_r == 3'(SUM_WORDS - 1));
    assign word_sel_out = sel_r;
    assign busy_out = (state_r != ST_IDLE);
    assign done_out = (state_r == ST_DONE);
    assign sum_out = sum_r;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: if (start_in) state_nxt = ST_ADD;
            ST_ADD: if (last_word) state_nxt = ST_DONE;
            ST_DONE: state_nxt = start_in ? ST_ADD : ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            state_r <= ST_IDLE;
            sel_r <= 3'h0;
            acc_r <= WORD_RESET;
            sum_r <= WORD_RESET;
        end else begin
            state_r <= state_nxt;
            sel_r <= (state_r == ST_ADD) ? sel_r + 3'h1 : 3'h0;
            acc_r <= (state_r == ST_ADD) ? folded : WORD_RESET;
            if (state_r == ST_ADD && last_word) begin
                sum_r <= ~folded;
            end
        end
    end
endmodule : checksum_engine

// ### hdl/amp_config_bank.sv
// configuration bank, checksum check and power-up sequencing
`timescale 1ns/1ps
// Function
// - swap bit exchanges the two front-end inputs
// - gain code picks gain 4 to 1600
// - offset is sign-magnitude, clamped at 100
// - range code picks offset scale factor
// - fault reference is supply or external reference
// - active-low pull-up control for open sensor
// - fault mode picks common-mode or bridge thresholds
// - enable bits switch each fault comparator group
// - group polarity forces output; external wins
// - limit reference is supply or external reference
// - limit enable switches the output clamps
// - limit codes pick eight threshold fractions
// - compensation bit picks heavy or light
// - link disable, instantly or after 25 ms
// - output on after 60 us or 25 ms
// - shared pin as digital output or clamp
// - shutdown bit selects low-current standby
// - sum words with end-around carry
// - device stores inverted sum for readback
// - flag shows computed equals stored checksum
module amp_config_bank
    import amp_cfg_pkg::*;
#(
    parameter int FAST_ON_CNT = FAST_ON_CYCLES,
    parameter int SLOW_DELAY_CNT = SLOW_DELAY_CYCLES
) (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic wr_en_in,
    input wire logic [3:0] wr_addr_in,
    input wire logic [15:0] wr_data_in,
    input wire logic [3:0] rd_addr_in,
    output logic [15:0] rd_data_out,
    input wire logic [3:0] ext_fault_in,
    input wire logic [4:0] int_fault_in,
    output logic vin1_is_positive_out,
    output logic [10:0] front_gain_out,
    output logic offset_negative_out,
    output logic [6:0] offset_magnitude_out,
    output logic [9:0] offset_scale_e4_out,
    output logic fault_ref_supply_out,
    output logic pullup_enable_out,
    output logic fault_common_mode_out,
    output logic ext_group_enable_out,
    output logic int_group_enable_out,
    output logic force_active_out,
    output logic force_level_out,
    output logic limit_ref_supply_out,
    output logic limit_clamp_enable_out,
    output logic [16:0] high_limit_e5_out,
    output logic [16:0] low_limit_e5_out,
    output logic heavy_comp_out,
    output logic link_active_out,
    output logic output_enable_out,
    output logic pin_digital_out,
    output logic pin_level_out,
    output logic standby_out,
    output logic checksum_ok_out
);
    typedef enum logic [1:0] {
        PU_WAIT_SUM = 2'b00,
        PU_DELAY = 2'b01,
        PU_ON = 2'b10,
        PU_HOLD = 2'b11
    } power_state_t;

    logic [15:0] fine_offset_word_r;
    logic [15:0] fine_gain_word_r;
    logic [15:0] gain_offset_config_r;
    logic [15:0] fault_and_limit_config_r;
    logic [15:0] link_output_power_config_r;
    logic [15:0] config_checksum_r;
    logic [15:0] checksum_readback_r;
    logic checksum_ok_flag_r;
    logic sum_valid_r;
    logic [15:0] rd_data_r;
    logic [15:0] rd_data_nxt;
    logic [15:0] status_word;
    logic sum_start_r;
    logic [2:0] sum_sel;
    logic [15:0] sum_word;
    logic sum_busy;
    logic sum_done;
    logic [15:0] sum_value;
    logic wr_cfg_word;
    logic [3:0] ext_meta_r;
    logic [3:0] ext_sync_r;
    logic [4:0] int_meta_r;
    logic [4:0] int_sync_r;
    logic ext_hit;
    logic int_hit;
    logic force_active_r;
    logic force_level_r;
    logic force_level_nxt;
    power_state_t pu_state_r;
    power_state_t pu_state_nxt;
    logic [TIMER_W-1:0] pu_count_r;
    logic [TIMER_W-1:0] pu_limit;
    logic pu_count_done;
    logic link_active_r;
    logic [TIMER_W-1:0] link_count_r;
    logic link_count_done;
    logic [6:0] offset_raw;
    logic [3:0] gain_code;
    logic [1:0] range_code;
    logic [2:0] hl_code;
    logic [2:0] ll_code;

    // whole-word register writes
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            fine_offset_word_r <= WORD_RESET;
            fine_gain_word_r <= WORD_RESET;
            gain_offset_config_r <= WORD_RESET;
            fault_and_limit_config_r <= WORD_RESET;
            link_output_power_config_r <= WORD_RESET;
            config_checksum_r <= WORD_RESET;
        end else if (wr_en_in) begin
            unique case (wr_addr_in)
                IDX_FINE_OFFSET: fine_offset_word_r <= wr_data_in;
                IDX_FINE_GAIN: fine_gain_word_r <= wr_data_in;
                IDX_GAIN_OFFSET: gain_offset_config_r <= wr_data_in;
                IDX_FAULT_LIMIT: fault_and_limit_config_r <= wr_data_in;
                IDX_LINK_OUTPUT: link_output_power_config_r <= wr_data_in;
                IDX_CHECKSUM: config_checksum_r <= wr_data_in;
                default: ;
            endcase
        end
    end

    // readback
    assign status_word = 16'(checksum_ok_flag_r) << POS_CHECKSUM_OK;
    always_comb begin
        unique case (rd_addr_in)
            IDX_FINE_OFFSET: rd_data_nxt = fine_offset_word_r;
            IDX_FINE_GAIN: rd_data_nxt = fine_gain_word_r;
            IDX_GAIN_OFFSET: rd_data_nxt = gain_offset_config_r;
            IDX_FAULT_LIMIT: rd_data_nxt = fault_and_limit_config_r;
            IDX_LINK_OUTPUT: rd_data_nxt = link_output_power_config_r;
            IDX_CHECKSUM: rd_data_nxt = config_checksum_r;
            IDX_CHECKSUM_READBACK: rd_data_nxt = checksum_readback_r;
            IDX_STATUS: rd_data_nxt = status_word;
            default: rd_data_nxt = WORD_RESET;
        endcase
    end
    always_ff @(posedge clock_in) begin
        rd_data_r <= sys_rst_in ? WORD_RESET : rd_data_nxt;
    end
    assign rd_data_out = rd_data_r;

    // recompute after reset and after any word write
    assign wr_cfg_word = wr_en_in && (wr_addr_in <= IDX_CHECKSUM);
    always_comb begin
        unique case (sum_sel)
            3'h0: sum_word = fine_offset_word_r;
            3'h1: sum_word = fine_gain_word_r;
            3'h2: sum_word = gain_offset_config_r;
            3'h3: sum_word = fault_and_limit_config_r;
            default: sum_word = link_output_power_config_r;
        endcase
    end

    checksum_engine u_checksum (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .start_in(sum_start_r),
        .word_in(sum_word),
        .word_sel_out(sum_sel),
        .busy_out(sum_busy),
        .done_out(sum_done),
        .sum_out(sum_value)
    );

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            sum_start_r <= 1'b1;
            sum_valid_r <= 1'b0;
            checksum_readback_r <= WORD_RESET;
            checksum_ok_flag_r <= 1'b0;
        end else begin
            // hold a pending restart until the engine takes it at done
            sum_start_r <= wr_cfg_word
                || (sum_start_r && sum_busy && !sum_done);
            if (sum_done && !sum_start_r) begin
                sum_valid_r <= 1'b1;
                checksum_readback_r <= sum_value;
                checksum_ok_flag_r <= (sum_value == config_checksum_r);
            end
        end
    end
    assign checksum_ok_out = checksum_ok_flag_r;

    // analog front-end controls
    assign offset_raw = gain_offset_config_r[POS_COARSE_OFFSET +: 7];
    assign gain_code = gain_offset_config_r[POS_FRONT_GAIN +: 4];
    assign range_code = link_output_power_config_r[POS_OFFSET_RANGE +: 2];
    assign hl_code = fault_and_limit_config_r[POS_HIGH_LIMIT +: 3];
    assign ll_code = fault_and_limit_config_r[POS_LOW_LIMIT +: 3];
    assign vin1_is_positive_out =
        gain_offset_config_r[POS_INPUT_SWAP];
    assign offset_negative_out =
        gain_offset_config_r[POS_COARSE_OFFSET + 7];
    assign offset_magnitude_out =
        (offset_raw > OFFSET_MAG_MAX) ? OFFSET_MAG_MAX : offset_raw;
    assign fault_ref_supply_out =
        fault_and_limit_config_r[POS_FAULT_REF];
    assign pullup_enable_out =
        !fault_and_limit_config_r[POS_PULLUP_DIS];
    assign fault_common_mode_out =
        fault_and_limit_config_r[POS_FAULT_MODE];
    assign ext_group_enable_out =
        fault_and_limit_config_r[POS_EXT_FAULT_GROUP_EN];
    assign int_group_enable_out =
        fault_and_limit_config_r[POS_INT_EN];
    assign limit_ref_supply_out =
        fault_and_limit_config_r[POS_LIMIT_REF];
    assign limit_clamp_enable_out =
        fault_and_limit_config_r[POS_LIMIT_EN];
    assign heavy_comp_out =
        fault_and_limit_config_r[POS_LIMIT_COMP];
    assign pin_digital_out =
        link_output_power_config_r[POS_PIN_DIGITAL];
    assign pin_level_out = pin_digital_out
        && link_output_power_config_r[POS_PIN_STATE];
    assign standby_out =
        link_output_power_config_r[POS_SHUTDOWN];

    always_comb begin
        unique case (gain_code)
            4'h0: front_gain_out = 11'd4;
            4'h1: front_gain_out = 11'd6;
            4'h2: front_gain_out = 11'd8;
            4'h3: front_gain_out = 11'd12;
            4'h4: front_gain_out = 11'd16;
            4'h5: front_gain_out = 11'd32;
            4'h6: front_gain_out = 11'd64;
            4'h7: front_gain_out = 11'd100;
            4'h8: front_gain_out = 11'd200;
            4'h9: front_gain_out = 11'd400;
            4'hA: front_gain_out = 11'd480;
            4'hB: front_gain_out = 11'd600;
            4'hC: front_gain_out = 11'd800;
            4'hD: front_gain_out = 11'd960;
            4'hE: front_gain_out = 11'd1200;
            4'hF: front_gain_out = 11'd1600;
        endcase
    end

    always_comb begin
        unique case (range_code)
            2'h0: offset_scale_e4_out = 10'd640;
            2'h1: offset_scale_e4_out = 10'd427;
            2'h2: offset_scale_e4_out = 10'd320;
            2'h3: offset_scale_e4_out = 10'd256;
        endcase
    end

    // thresholds in units of 1e-5 of the limit reference
    always_comb begin
        unique case (hl_code)
            3'h0: high_limit_e5_out = 17'd98050;
            3'h1: high_limit_e5_out = 17'd96880;
            3'h2: high_limit_e5_out = 17'd96090;
            3'h3: high_limit_e5_out = 17'd94920;
            3'h4: high_limit_e5_out = 17'd85160;
            3'h5: high_limit_e5_out = 17'd77730;
            3'h6: high_limit_e5_out = 17'd62890;
            3'h7: high_limit_e5_out = 17'd57030;
        endcase
        unique case (ll_code)
            3'h0: low_limit_e5_out = 17'd1953;
            3'h1: low_limit_e5_out = 17'd2343;
            3'h2: low_limit_e5_out = 17'd3125;
            3'h3: low_limit_e5_out = 17'd3516;
            3'h4: low_limit_e5_out = 17'd3906;
            3'h5: low_limit_e5_out = 17'd4688;
            3'h6: low_limit_e5_out = 17'd5078;
            3'h7: low_limit_e5_out = 17'd5470;
        endcase
    end

    // comparator levels arrive from the analog side
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            ext_meta_r <= 4'h0;
            ext_sync_r <= 4'h0;
            int_meta_r <= 5'h00;
            int_sync_r <= 5'h00;
        end else begin
            ext_meta_r <= ext_fault_in;
            ext_sync_r <= ext_meta_r;
            int_meta_r <= int_fault_in;
            int_sync_r <= int_meta_r;
        end
    end

    assign ext_hit = ext_group_enable_out && (|ext_sync_r);
    assign int_hit = int_group_enable_out && (|int_sync_r);
    assign force_level_nxt = ext_hit
        ? fault_and_limit_config_r[POS_EXT_FAULT_POLARITY]
        : fault_and_limit_config_r[POS_INT_FAULT_POLARITY];
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            force_active_r <= 1'b0;
            force_level_r <= 1'b0;
        end else begin
            force_active_r <= ext_hit || int_hit;
            force_level_r <= force_level_nxt;
        end
    end
    assign force_active_out = force_active_r;
    assign force_level_out = force_active_r && force_level_r;

    // power-up output sequencing
    assign pu_limit = link_output_power_config_r[POS_INSTANT_ON]
        ? TIMER_W'(FAST_ON_CNT) : TIMER_W'(SLOW_DELAY_CNT);
    assign pu_count_done = (pu_count_r >= pu_limit - TIMER_W'(1));
    always_comb begin
        pu_state_nxt = pu_state_r;
        unique case (pu_state_r)
            PU_WAIT_SUM: if (sum_valid_r) begin
                pu_state_nxt = checksum_ok_flag_r ? PU_DELAY : PU_HOLD;
            end
            // a bad checksum takes the output back off
            PU_DELAY: if (!checksum_ok_flag_r) begin
                pu_state_nxt = PU_HOLD;
            end else if (pu_count_done) begin
                pu_state_nxt = PU_ON;
            end
            PU_ON: if (!checksum_ok_flag_r) pu_state_nxt = PU_HOLD;
            PU_HOLD: if (checksum_ok_flag_r) pu_state_nxt = PU_DELAY;
        endcase
    end
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            pu_state_r <= PU_WAIT_SUM;
            pu_count_r <= '0;
        end else begin
            pu_state_r <= pu_state_nxt;
            pu_count_r <= (pu_state_r == PU_DELAY)
                ? pu_count_r + TIMER_W'(1) : '0;
        end
    end
    assign output_enable_out = (pu_state_r == PU_ON)
        && checksum_ok_flag_r
        && !link_output_power_config_r[POS_OUT_DIS]
        && !standby_out;

    // one-wire shutdown timing
    assign link_count_done =
        (link_count_r >= TIMER_W'(SLOW_DELAY_CNT) - TIMER_W'(1));
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            link_active_r <= 1'b1;
            link_count_r <= '0;
        end else if (!link_output_power_config_r[POS_LINK_DIS]) begin
            link_active_r <= 1'b1;
            link_count_r <= '0;
        end else if (link_output_power_config_r[POS_LINK_DIS_NOW]) begin
            link_active_r <= 1'b0;
        end else if (link_count_done) begin
            link_active_r <= 1'b0;
        end else begin
            link_count_r <= link_count_r + TIMER_W'(1);
        end
    end
    // instant disable acts in the write cycle's aftermath
    assign link_active_out = link_active_r
        && !(link_output_power_config_r[POS_LINK_DIS]
        && link_output_power_config_r[POS_LINK_DIS_NOW]);
endmodule : amp_config_bank

// ### tb/cal_ctrl_model.sv
// calibration controller model driving the write port
`timescale 1ns/1ps
module cal_ctrl_model
    import amp_cfg_pkg::*;
(
    input wire logic clock_in,
    output logic wr_en_out,
    output logic [3:0] wr_addr_out,
    output logic [15:0] wr_data_out
);
    logic [15:0] sh_r[0:4];
    initial begin
        wr_en_out = 1'b0;
        wr_addr_out = 4'h0;
        wr_data_out = 16'h0000;
    end
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        logic [15:0] x;
        x = (a == IDX_LINK_OUTPUT) ? (d & 16'hFDC0) : d;
        if (a < IDX_CHECKSUM) sh_r[a] = x;
        @(negedge clock_in);
        wr_en_out = 1'b1;
        wr_addr_out = a;
        wr_data_out = x;
        @(negedge clock_in);
        wr_en_out = 1'b0;
        wr_addr_out = ~a;
        wr_data_out = ~x;
    endtask : wr
    // bad flips the lsb so a wrong checksum is stored
    task automatic send_sum(input logic bad);
        logic [16:0] s;
        s = 17'h00000;
        for (int i = 0; i < SUM_WORDS; i++) begin
            s = {1'b0, s[15:0]} + {1'b0, sh_r[i]};
            s = {1'b0, s[15:0]} + {16'h0000, s[16]};
        end
        wr(IDX_CHECKSUM, ~s[15:0] ^ {15'h0000, bad});
    endtask : send_sum
endmodule : cal_ctrl_model

// ### tb/amp_config_bank_asserts.sv
// port checks for the configuration bank
`timescale 1ns/1ps
module amp_config_bank_asserts
    import amp_cfg_pkg::*;
(
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic wr_en_in,
    input wire logic [3:0] wr_addr_in,
    input wire logic [15:0] wr_data_in,
    input wire logic [3:0] rd_addr_in,
    input wire logic [15:0] rd_data_out,
    input wire logic [3:0] ext_fault_in,
    input wire logic [4:0] int_fault_in,
    input wire logic force_active_out,
    input wire logic force_level_out,
    input wire logic link_active_out,
    input wire logic output_enable_out,
    input wire logic pin_digital_out,
    input wire logic pin_level_out,
    input wire logic standby_out,
    input wire logic checksum_ok_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    wire logic link_output_power_config_wr = wr_en_in && wr_addr_in == IDX_LINK_OUTPUT;
    sequence s_wr;
        wr_en_in && wr_addr_in == IDX_FAULT_LIMIT;
    endsequence
    sequence s_look;
        !wr_en_in && rd_addr_in == IDX_FAULT_LIMIT;
    endsequence
    sequence s_quiet;
        (ext_fault_in == 4'h0 && int_fault_in == 5'h00) [*5];
    endsequence
    property p_whole;
        s_wr ##1 s_look |=> rd_data_out == $past(wr_data_in, 2);
    endproperty
    a_whole: assert property (p_whole)
        else $error("word read back differs");
    property p_release; s_quiet |-> !force_active_out; endproperty
    a_release: assert property (p_release)
        else $error("force held without fault");
    property p_idle; !force_active_out |-> !force_level_out; endproperty
    a_idle: assert property (p_idle)
        else $error("force level without force");
    property p_link_on;
        link_output_power_config_wr && !wr_data_in[15] |-> ##[1:2] link_active_out;
    endproperty
    a_link_on: assert property (p_link_on)
        else $error("link not enabled");
    property p_link_now;
        link_output_power_config_wr && wr_data_in[15] && wr_data_in[14] |=> !link_active_out;
    endproperty
    a_link_now: assert property (p_link_now)
        else $error("link not off at once");
    property p_standby; standby_out |-> !output_enable_out; endproperty
    a_standby: assert property (p_standby)
        else $error("output on in standby");
    property p_on_ok; $rose(output_enable_out) |-> checksum_ok_out; endproperty
    a_on_ok: assert property (p_on_ok)
        else $error("output on without valid checksum");
    property p_pin; !pin_digital_out |-> !pin_level_out; endproperty
    a_pin: assert property (p_pin)
        else $error("pin level outside digital mode");
endmodule : amp_config_bank_asserts
bind amp_config_bank amp_config_bank_asserts chk_u (.clock_in(clock_in),
    .sys_rst_in(sys_rst_in), .wr_en_in(wr_en_in), .wr_addr_in(wr_addr_in),
    .wr_data_in(wr_data_in), .rd_addr_in(rd_addr_in),
    .rd_data_out(rd_data_out), .ext_fault_in(ext_fault_in),
    .int_fault_in(int_fault_in), .force_active_out(force_active_out),
    .force_level_out(force_level_out), .link_active_out(link_active_out),
    .output_enable_out(output_enable_out), .standby_out(standby_out),
    .pin_digital_out(pin_digital_out), .pin_level_out(pin_level_out),
    .checksum_ok_out(checksum_ok_out));

// ### tb/amp_config_bank_tb.sv
// self-checking bench for the configuration bank
`timescale 1ns/1ps
module amp_config_bank_tb;
    import amp_cfg_pkg::*;
    localparam int GN[16] = '{4, 6, 8, 12, 16, 32, 64, 100, 200, 400, 480,
        600, 800, 960, 1200, 1600};
    localparam int SC[4] = '{640, 427, 320, 256};
    localparam int HI[8] = '{98050, 96880, 96090, 94920, 85160, 77730,
        62890, 57030};
    localparam int LO[8] = '{1953, 2343, 3125, 3516, 3906, 4688, 5078, 5470};
    logic clock_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [3:0] rd_a = 4'h0;
    logic [3:0] ef = 4'h0;
    logic [4:0] nf = 5'h00;
    logic [3:0] wa;
    logic [15:0] wd, rdd, v;
    logic [15:0] w[0:4];
    logic [10:0] gn;
    logic [9:0] sc;
    logic [6:0] mg;
    logic [16:0] hl, ll;
    logic we, swp, ng, fr, pu, cm, xe, ie, fa, fl, lr, lc, hc, lk, oe, pd;
    logic pl, sb, ok, xh, ih;
    int fail_count = 0;
    int n_compared = 0;
    int seed = 71;
    always #5 clock_in = ~clock_in;
    cal_ctrl_model cal_u (.clock_in(clock_in), .wr_en_out(we),
        .wr_addr_out(wa), .wr_data_out(wd));
    amp_config_bank #(.FAST_ON_CNT(20), .SLOW_DELAY_CNT(50)) dut_u (
        .clock_in(clock_in), .sys_rst_in(sys_rst_in), .wr_en_in(we),
        .wr_addr_in(wa), .wr_data_in(wd), .rd_addr_in(rd_a),
        .rd_data_out(rdd), .ext_fault_in(ef), .int_fault_in(nf),
        .vin1_is_positive_out(swp), .front_gain_out(gn),
        .offset_negative_out(ng), .offset_magnitude_out(mg),
        .offset_scale_e4_out(sc), .fault_ref_supply_out(fr),
        .pullup_enable_out(pu), .fault_common_mode_out(cm),
        .ext_group_enable_out(xe), .int_group_enable_out(ie),
        .force_active_out(fa), .force_level_out(fl), .heavy_comp_out(hc),
        .limit_ref_supply_out(lr), .limit_clamp_enable_out(lc),
        .high_limit_e5_out(hl), .low_limit_e5_out(ll), .link_active_out(lk),
        .output_enable_out(oe), .pin_digital_out(pd), .pin_level_out(pl),
        .standby_out(sb), .checksum_ok_out(ok));
    task automatic chk(input string nm, input logic [16:0] e, g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s exp %0h got %0h", nm, e, g);
        end
    endtask : chk
    task automatic rd(input logic [3:0] a);
        @(negedge clock_in);
        rd_a = a;
        @(negedge clock_in);
        v = rdd;
    endtask : rd
    function automatic logic [15:0] csum();
        logic [16:0] s;
        s = 17'h00000;
        for (int i = 0; i < 5; i++) begin
            s = s + w[i];
            s = s[16] ? s - 17'h0FFFF : s;
        end
        return ~s[15:0];
    endfunction : csum
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim
    initial begin
        #100us;
        fail_count++;
        end_sim();
    end
    initial begin
        repeat (3) @(negedge clock_in);
        sys_rst_in = 1'b0;
        repeat (12) @(negedge clock_in);
        chk("reset", 3'b100, {lk, oe, ok});
        rd(IDX_CHECKSUM);
        chk("reset word", 16'h0000, v);
        rd(IDX_CHECKSUM_READBACK);
        chk("reset sum", 16'hFFFF, v);
        for (int k = 0; k < 16; k++) begin
            for (int i = 0; i < 5; i++) w[i] = 16'($random(seed));
            w[2][11:8] = k[3:0];
            if (k < 3) w[2][6:0] = 7'h63 + k[6:0];
            w[4] = w[4] & 16'hFDC0;
            rd_a = IDX_FAULT_LIMIT;
            for (int i = 0; i < 5; i++) cal_u.wr(i[3:0], w[i]);
            cal_u.send_sum(1'b0);
            repeat (12) @(negedge clock_in);
            chk("early", 2'b10, {ok, oe});
            rd(IDX_CHECKSUM_READBACK);
            chk("sum", csum(), v);
            rd(IDX_FAULT_LIMIT);
            chk("word", w[3], v);
            chk("bits", {w[2][12], w[2][7], w[3][15], !w[3][14], w[3][12],
                w[3][11], w[3][10], w[3][9], w[3][6], w[3][13], w[4][8],
                w[4][8] & w[4][7], w[4][6]}, {swp, ng, fr, pu, cm, hc, xe,
                ie, lc, lr, pd, pl, sb});
            chk("gain", 17'(GN[k]), gn);
            chk("mag", (w[2][6:0] > 7'h64) ? 7'h64 : w[2][6:0], mg);
            chk("scale", 17'(SC[w[4][11:10]]), sc);
            chk("high", 17'(HI[w[3][5:3]]), hl);
            chk("low", 17'(LO[w[3][2:0]]), ll);
            ef = (k % 4 == 0) ? 4'h0 : 4'($random(seed));
            nf = 5'($random(seed));
            xh = w[3][10] && ef != 4'h0;
            ih = w[3][9] && nf != 5'h00;
            repeat (5) @(negedge clock_in);
            chk("force", {xh || ih, xh ? w[3][8] : ih && w[3][7]},
                {fa, fl});
            ef = 4'h0;
            nf = 5'h00;
            repeat (5) @(negedge clock_in);
            chk("release", 2'b00, {fa, fl});
            repeat (11) @(negedge clock_in);
            chk("mid", w[4][12] && !w[4][13] && !w[4][6], oe);
            repeat (30) @(negedge clock_in);
            chk("late", {!w[4][13] && !w[4][6], !w[4][15]},
                {oe, lk});
            rd(IDX_STATUS);
            chk("status", 16'h0040, v);
            cal_u.send_sum(1'b1);
            repeat (12) @(negedge clock_in);
            chk("bad", 2'b00, {ok, oe});
        end
        cal_u.wr(IDX_CHECKSUM_READBACK, 16'h1234);
        rd(IDX_CHECKSUM_READBACK);
        chk("read only", csum(), v);
        rd(4'h9);
        chk("unmapped", 16'h0000, v);
        end_sim();
    end
endmodule : amp_config_bank_tb
